// *** rtl/cs_pkg.sv ***
// constants, register map and decode helpers for the sensing config block
package cs_pkg;
  localparam int NUM_CH = 13;
  localparam int PROX_CH = 12;
  localparam int NUM_ELE = 12;
  localparam int TW = 24;
  localparam int CUR_W = 6;
  localparam int TIM_W = 3;
  localparam int CH_W = 4;

  localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h5c;
  localparam logic [7:0] ADDR_GLOBAL_TIME = 8'h5d;
  localparam logic [7:0] ADDR_CH_CURRENT_FIRST = 8'h5f;
  localparam logic [7:0] ADDR_CH_CURRENT_LAST = 8'h6b;

  localparam logic [7:0] RESET_GLOBAL_CURRENT = 8'h10;
  localparam logic [7:0] RESET_GLOBAL_TIME = 8'h24;
  localparam logic [7:0] RESET_CH_CURRENT = 8'h00;

  localparam int FIRST_CNT_LSB = 6;
  localparam int CUR_LSB = 0;
  localparam int TIME_LSB = 5;
  localparam int SECOND_CNT_LSB = 3;
  localparam int IVL_LSB = 0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_US_NS = 500;
  localparam int MS_NS = 1000000;
  localparam int HALF_US_CYCLES = HALF_US_NS / CLK_PERIOD_NS;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [11:0] HALF_US_CYC = 12'(HALF_US_CYCLES);
  localparam logic [7:0] ONE_MS = 8'h01;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_TRIAL = 2'b01,
    CS_WAIT = 2'b10,
    CS_NEXT = 2'b11
  } cs_search_type;

  function automatic logic [5:0] first_count(input logic [1:0] code);
    case (code)
      2'b00: first_count = 6'h06;
      2'b01: first_count = 6'h0a;
      2'b10: first_count = 6'h12;
      default: first_count = 6'h22;
    endcase
  endfunction

  function automatic logic [4:0] second_count(input logic [1:0] code);
    case (code)
      2'b00: second_count = 5'h04;
      2'b01: second_count = 5'h06;
      2'b10: second_count = 5'h0a;
      default: second_count = 5'h12;
    endcase
  endfunction

  function automatic logic [11:0] time_cycles(input logic [2:0] code);
    if (code == 3'b000)
      time_cycles = 12'h000;
    else
      time_cycles = HALF_US_CYC << (code - 3'b001);
  endfunction
endpackage

// *** rtl/cs_sample_timer.sv ***
// sample period timer, stretched to the scan time when that is longer
`timescale 1ns/1ps
module cs_sample_timer
  import cs_pkg::*;
#(
  parameter int W = TW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] interval_cycles,
  input wire logic [W-1:0] scan_cycles,
  output logic tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] period;
  logic last;

  assign period = (scan_cycles > interval_cycles) ? scan_cycles :
                  interval_cycles;
  assign last = run && (cnt_q + W'(1) >= period);
  assign cnt_d = !run ? '0 : (last ? '0 : cnt_q + W'(1));
  assign tick = last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** rtl/cs_afe_config.sv ***
// global and per-channel measurement configuration with auto search
`timescale 1ns/1ps
module cs_afe_config
  import cs_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] electrode_enable_field,
  input wire logic [1:0] prox_enable_field,
  input wire logic auto_config_enable,
  input wire logic skip_time_search,
  input wire logic trial_done,
  input wire logic trial_over,
  output logic trial_req,
  output logic [CH_W-1:0] trial_channel,
  output logic [CUR_W-1:0] trial_current,
  output logic [TIM_W-1:0] trial_time,
  output logic run_mode,
  output logic search_busy,
  output logic sample_tick,
  output logic [NUM_CH-1:0] channel_active,
  output logic [5:0] first_stage_count,
  output logic [4:0] second_stage_count,
  output logic [7:0] sample_interval_ms,
  output logic [TW-1:0] scan_cycles,
  output logic [NUM_CH*CUR_W-1:0] eff_current_flat,
  output logic [NUM_CH*TIM_W-1:0] eff_time_flat
);
  logic rst_meta_q;
  logic rst_n_s;
  logic [7:0] gcur_q;
  logic [7:0] gtim_q;
  logic [CUR_W-1:0] ch_cur_q [NUM_CH];
  logic [TIM_W-1:0] ch_tim_q [NUM_CH];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic searched_q;
  cs_search_type st_q;
  logic time_phase_q;
  logic [CH_W-1:0] ch_q;
  logic [2:0] bit_q;
  logic [CUR_W-1:0] cand_cur_q;
  logic [TIM_W-1:0] cand_tim_q;
  logic req_q;

  logic [1:0] first_code;
  logic [5:0] cur_code;
  logic [2:0] tim_code;
  logic [1:0] second_code;
  logic [2:0] ivl_code;
  logic run_w;
  logic start_search;
  logic wr_gcur;
  logic wr_gtim;
  logic ch_addr_hit;
  logic [7:0] ch_idx8;
  logic [CH_W-1:0] ch_idx;
  logic [NUM_CH-1:0] active_w;
  logic [CUR_W-1:0] eff_cur [NUM_CH];
  logic [TIM_W-1:0] eff_tim [NUM_CH];
  logic [TW-1:0] scan_sum;
  logic [TW-1:0] interval_w;
  logic tick_w;
  logic ch_on;
  logic last_ch;
  logic [CUR_W-1:0] try_cur;
  logic [TIM_W-1:0] try_tim;
  logic [CUR_W-1:0] kept_cur;
  logic [TIM_W-1:0] kept_tim;
  logic phase_end;
  logic [2:0] bit_first;
  logic timer_run;
  logic trial_load;
  logic store_ch;
  logic [CUR_W-1:0] trial_cur_sel;
  logic [TIM_W-1:0] trial_tim_sel;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_s <= rst_meta_q;
    end
  end

  // field decode
  assign first_code = gcur_q[FIRST_CNT_LSB+1:FIRST_CNT_LSB];
  assign cur_code = gcur_q[CUR_LSB+CUR_W-1:CUR_LSB];
  assign tim_code = gtim_q[TIME_LSB+TIM_W-1:TIME_LSB];
  assign second_code = gtim_q[SECOND_CNT_LSB+1:SECOND_CNT_LSB];
  assign ivl_code = gtim_q[IVL_LSB+TIM_W-1:IVL_LSB];

  // run mode and enabled channels
  assign run_w = (electrode_enable_field != 4'h0) ||
                 (prox_enable_field != 2'b00);
  generate
    for (genvar i = 0; i < NUM_ELE; i++) begin : g_act
      assign active_w[i] = (electrode_enable_field > 4'(i));
    end
  endgenerate
  assign active_w[PROX_CH] = (prox_enable_field != 2'b00);

  // register port decode
  assign wr_gcur = reg_wr_en && (reg_addr == ADDR_GLOBAL_CURRENT);
  assign wr_gtim = reg_wr_en && (reg_addr == ADDR_GLOBAL_TIME);
  assign ch_addr_hit = (reg_addr >= ADDR_CH_CURRENT_FIRST) &&
                       (reg_addr <= ADDR_CH_CURRENT_LAST);
  assign ch_idx8 = reg_addr - ADDR_CH_CURRENT_FIRST;
  assign ch_idx = ch_idx8[CH_W-1:0];

  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == ADDR_GLOBAL_CURRENT)
      rdata_d = gcur_q;
    else if (reg_addr == ADDR_GLOBAL_TIME)
      rdata_d = gtim_q;
    else if (ch_addr_hit)
      rdata_d = {2'b00, ch_cur_q[ch_idx]};
  end

  // effective per-channel settings and scan length
  always_comb begin
    scan_sum = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      eff_cur[i] = (ch_cur_q[i] != '0) ? ch_cur_q[i] : cur_code;
      eff_tim[i] = (ch_tim_q[i] != '0) ? ch_tim_q[i] : tim_code;
      if (active_w[i])
        scan_sum = scan_sum + TW'(first_count(first_code)) *
                   (TW'(time_cycles(eff_tim[i])) << 1);
    end
  end

  assign interval_w = TW'(CYCLES_PER_MS) << ivl_code;

  cs_sample_timer #(
    .W(TW)
  ) u_timer (
    .clk(ref_clk),
    .rst_n(rst_n_s),
    .run(timer_run),
    .interval_cycles(interval_w),
    .scan_cycles(scan_sum),
    .tick(tick_w)
  );

  // search step helpers
  assign start_search = run_w && auto_config_enable && !searched_q;
  assign ch_on = active_w[ch_q];
  assign last_ch = (ch_q == CH_W'(PROX_CH));
  assign try_cur = cand_cur_q | (CUR_W'(1) << bit_q);
  assign try_tim = cand_tim_q | (TIM_W'(1) << bit_q);
  assign kept_cur = trial_over ? cand_cur_q : try_cur;
  assign kept_tim = trial_over ? cand_tim_q : try_tim;
  assign phase_end = (bit_q == 3'b000);
  assign bit_first = skip_time_search ? 3'(CUR_W - 1) : 3'(TIM_W - 1);
  assign timer_run = run_w && (st_q == CS_IDLE);
  assign trial_load = (st_q == CS_TRIAL) && ch_on;
  assign store_ch = (st_q == CS_NEXT) && ch_on;
  assign trial_cur_sel = time_phase_q ? cur_code : try_cur;
  assign trial_tim_sel = time_phase_q ? try_tim :
                         skip_time_search ? eff_tim[ch_q] :
                         cand_tim_q;

  // global registers
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      gcur_q <= RESET_GLOBAL_CURRENT;
      gtim_q <= RESET_GLOBAL_TIME;
    end else begin
      if (wr_gcur)
        gcur_q <= reg_wdata;
      if (wr_gtim)
        gtim_q <= reg_wdata;
    end
  end

  // read data holds until the next read
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_q <= rdata_d;
    end
  end

  // per-channel registers; a search result beats a host write
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_cur_q[i] <= RESET_CH_CURRENT[CUR_W-1:0];
        ch_tim_q[i] <= '0;
      end
    end else begin
      if (reg_wr_en && ch_addr_hit)
        ch_cur_q[ch_idx] <= reg_wdata[CUR_W-1:0];
      if (store_ch) begin
        ch_cur_q[ch_q] <= cand_cur_q;
        if (!skip_time_search)
          ch_tim_q[ch_q] <= cand_tim_q;
      end
    end
  end

  // trial search engine
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_q <= CS_IDLE;
      searched_q <= 1'b0;
      time_phase_q <= 1'b0;
      ch_q <= '0;
      bit_q <= '0;
      cand_cur_q <= '0;
      cand_tim_q <= '0;
      req_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      unique case (st_q)
        CS_IDLE: begin
          if (start_search) begin
            searched_q <= 1'b1;
            ch_q <= '0;
            cand_cur_q <= '0;
            cand_tim_q <= '0;
            time_phase_q <= !skip_time_search;
            bit_q <= bit_first;
            st_q <= CS_TRIAL;
          end
        end
        CS_TRIAL: begin
          if (!ch_on) begin
            st_q <= CS_NEXT;
          end else begin
            req_q <= 1'b1;
            st_q <= CS_WAIT;
          end
        end
        CS_WAIT: begin
          if (trial_done) begin
            if (time_phase_q)
              cand_tim_q <= kept_tim;
            else
              cand_cur_q <= kept_cur;
            if (!phase_end) begin
              bit_q <= bit_q - 3'b001;
              st_q <= CS_TRIAL;
            end else if (time_phase_q) begin
              time_phase_q <= 1'b0;
              bit_q <= 3'(CUR_W - 1);
              st_q <= CS_TRIAL;
            end else begin
              st_q <= CS_NEXT;
            end
          end
        end
        CS_NEXT: begin
          cand_cur_q <= '0;
          cand_tim_q <= '0;
          time_phase_q <= !skip_time_search;
          bit_q <= bit_first;
          if (last_ch) begin
            st_q <= CS_IDLE;
          end else begin
            ch_q <= ch_q + CH_W'(1);
            st_q <= CS_TRIAL;
          end
        end
      endcase
    end
  end

  // trial outputs; skipped time search trials with existing times
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      trial_channel <= '0;
      trial_current <= '0;
      trial_time <= '0;
    end else if (trial_load) begin
      trial_channel <= ch_q;
      trial_current <= trial_cur_sel;
      trial_time <= trial_tim_sel;
    end
  end

  // registered status and shared settings
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      run_mode <= 1'b0;
      sample_tick <= 1'b0;
      channel_active <= '0;
      first_stage_count <= '0;
      second_stage_count <= '0;
      sample_interval_ms <= '0;
      scan_cycles <= '0;
    end else begin
      run_mode <= run_w;
      sample_tick <= tick_w;
      channel_active <= active_w;
      first_stage_count <= first_count(first_code);
      second_stage_count <= second_count(second_code);
      sample_interval_ms <= ONE_MS << ivl_code;
      scan_cycles <= scan_sum;
    end
  end

  // effective per-channel settings, one flat word each
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      eff_current_flat <= '0;
      eff_time_flat <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        eff_current_flat[i*CUR_W +: CUR_W] <= eff_cur[i];
        eff_time_flat[i*TIM_W +: TIM_W] <= eff_tim[i];
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign trial_req = req_q;
  assign search_busy = (st_q != CS_IDLE);
endmodule

// *** verification/cs_afe_config_props.sv ***
// port assertions for the sensing configuration block
`timescale 1ns/1ps
module cs_afe_config_props
  import cs_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] electrode_enable_field,
  input wire logic [1:0] prox_enable_field,
  input wire logic trial_req,
  input wire logic [CUR_W-1:0] trial_current,
  input wire logic [TIM_W-1:0] trial_time,
  input wire logic run_mode,
  input wire logic [5:0] first_stage_count,
  input wire logic [7:0] sample_interval_ms
);
  logic [1:0] live_q;
  wire live = live_q == 2'h3;
  wire en_any = electrode_enable_field != 4'h0 || prox_enable_field != 2'h0;
  wire cur_sel = reg_addr == ADDR_GLOBAL_CURRENT;
  wire mapped = cur_sel || reg_addr == ADDR_GLOBAL_TIME ||
    (reg_addr >= ADDR_CH_CURRENT_FIRST && reg_addr <= ADDR_CH_CURRENT_LAST);
  // edges since reset release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      live_q <= 2'h0;
    else if (!live)
      live_q <= live_q + 2'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!live);
  wr_rd_a: assert property (
    reg_wr_en && cur_sel ##1 reg_rd_en && cur_sel |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("read after write");
  unmapped_rd_a: assert property (
    reg_rd_en && !mapped |=> reg_rdata == 8'h00) else $error("unmapped read");
  rdata_hold_a: assert property (
    !reg_rd_en |=> $stable(reg_rdata)) else $error("read data moved");
  run_follow_a: assert property (
    ##1 run_mode == $past(en_any)) else $error("run mode wrong");
  req_pulse_a: assert property (
    trial_req |=> !trial_req) else $error("trial request too long");
  req_stable_a: assert property (
    !trial_req |-> $stable({trial_current, trial_time}))
    else $error("trial settings moved");
  first_count_a: assert property (
    reg_wr_en && cur_sel |-> ##2
    first_stage_count == (6'h04 << $past(reg_wdata[7:6], 2)) + 6'h02)
    else $error("first stage count wrong");
  interval_map_a: assert property (
    reg_wr_en && reg_addr == ADDR_GLOBAL_TIME |-> ##2
    sample_interval_ms == 8'h01 << $past(reg_wdata[2:0], 2))
    else $error("sample interval wrong");
  cover property (trial_req && trial_time != 3'h0);
  cover property (reg_rd_en && !mapped);
  cover property (run_mode && $rose(trial_req));
endmodule
bind cs_afe_config cs_afe_config_props
  #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (.ref_clk, .rstn, .reg_wr_en,
  .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .electrode_enable_field,
  .prox_enable_field, .trial_req, .trial_current, .trial_time, .run_mode,
  .first_stage_count, .sample_interval_ms);

// *** verification/tb_cs_afe_config.sv ***
// self-checking bench for the sensing configuration block
`timescale 1ns/1ps
module tb_cs_afe_config;
  import cs_pkg::*;
  localparam int CPM = 10;
  logic ref_clk = 0, rstn = 0, reg_wr_en = 0, reg_rd_en = 0;
  logic auto_config_enable = 0, skip_time_search = 0;
  logic trial_done = 0, trial_over = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, sample_interval_ms;
  logic [3:0] electrode_enable_field = 0;
  logic [1:0] prox_enable_field = 0;
  logic trial_req, run_mode, search_busy, sample_tick;
  logic [CH_W-1:0] trial_channel;
  logic [CUR_W-1:0] trial_current;
  logic [TIM_W-1:0] trial_time;
  logic [NUM_CH-1:0] channel_active;
  logic [5:0] first_stage_count, v, g;
  logic [4:0] second_stage_count;
  logic [TW-1:0] scan_cycles;
  logic [NUM_CH*CUR_W-1:0] eff_current_flat;
  logic [NUM_CH*TIM_W-1:0] eff_time_flat;
  logic [7:0] d, cv[NUM_CH];
  logic [2:0] t;
  int error_cnt = 0, total_checks = 0, n, p;
  int first_t[4] = '{6, 10, 18, 34};
  int second_t[4] = '{4, 6, 10, 18};

  cs_afe_config #(.CYCLES_PER_MS(CPM)) u_dut (.ref_clk, .rstn, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .electrode_enable_field,
    .prox_enable_field, .auto_config_enable, .skip_time_search, .trial_done,
    .trial_over, .trial_req, .trial_channel, .trial_current, .trial_time,
    .run_mode, .search_busy, .sample_tick, .channel_active,
    .first_stage_count, .second_stage_count, .sample_interval_ms,
    .scan_cycles, .eff_current_flat, .eff_time_flat);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic int scan_exp(int f, int c, int ch);
    return ch * f * 2 * (HALF_US_CYCLES << (c - 1));
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  task automatic wait_lvl(input bit busy, input logic lvl);
    int w = 0;
    @(negedge ref_clk);
    while ((busy ? search_busy : trial_req) !== lvl && w < 400) begin
      @(negedge ref_clk);
      w++;
    end
    if (w >= 400) begin
      error_cnt++;
      $display("wrong value at %0t: wait ran out", $time);
      stop_test();
    end
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    reg_wr_en <= 1'b1;
    reg_rd_en <= 1'b0;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge ref_clk);
  endtask

  task automatic idle();
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
    @(posedge ref_clk);
  endtask

  // last of three tick intervals, clear of any config change
  task automatic period(output int q);
    for (int k = 0; k < 3; k++) begin
      q = 0;
      do begin
        @(negedge ref_clk);
        q++;
      end while (sample_tick !== 1'b1 && q < 20000);
      if (q >= 20000) begin
        chk(q, 0);
        stop_test();
      end
    end
    @(posedge ref_clk);
  endtask

  task automatic trials(input int k0, input bit tph, input logic [5:0] r,
    output logic [5:0] res);
    logic ov;
    res = 6'h00;
    for (int k = k0 - 1; k >= 0; k--) begin
      wait_lvl(1'b0, 1'b1);
      chk(trial_channel, 4'h0);
      chk(tph ? trial_current : 6'(trial_time), r);
      ov = 1'($urandom);
      if (!ov) res[k] = 1'b1;
      @(posedge ref_clk);
      trial_done <= 1'b1;
      trial_over <= ov;
      @(posedge ref_clk);
      trial_done <= 1'b0;
    end
  endtask

  initial begin
    void'($urandom(32'h3a5c));
    do_reset();
    rd(8'h5c, 8'h10);
    rd(8'h5d, 8'h24);
    chk(first_stage_count, 6);
    chk(second_stage_count, 4);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      d = {3'($urandom), i[1:0], i[2:0]};
      g = 6'($urandom);
      wr(8'h5d, d);
      wr(8'h5c, {i[1:0], g});
      rd(8'h5c, {i[1:0], g});
      rd(8'h5d, d);
      chk(first_stage_count, first_t[i % 4]);
      chk(second_stage_count, second_t[i % 4]);
      chk(sample_interval_ms, 1 << i);
      electrode_enable_field <= 4'($urandom);
      prox_enable_field <= 2'($urandom);
      repeat (2) idle();
      n = electrode_enable_field;
      chk(run_mode, n != 0 || prox_enable_field != 0);
      chk(channel_active, {prox_enable_field != 0,
        n >= 12 ? 12'hfff : 12'((1 << n) - 1)});
    end
    for (int c = 0; c < NUM_CH; c++) begin
      cv[c] = (c % 3 == 0) ? 8'h00 : 8'($urandom);
      wr(8'(8'h5f + c), cv[c]);
    end
    for (int c = 0; c < NUM_CH; c++) rd(8'(8'h5f + c), cv[c] & 8'h3f);
    rd(8'h5e, 8'h00);
    rd(8'h6c, 8'h00);
    $display("test register map done");
    g = 6'($urandom_range(63, 1));
    wr(8'h5c, {2'b00, g});
    wr(8'h5d, 8'h20);
    idle();
    electrode_enable_field <= 4'hc;
    prox_enable_field <= 2'h1;
    repeat (3) idle();
    for (int c = 0; c < NUM_CH; c++) begin
      v = cv[c][5:0] != 0 ? cv[c][5:0] : g;
      chk(eff_current_flat[6*c +: 6], v);
      chk(eff_time_flat[3*c +: 3], 3'h1);
    end
    chk(scan_cycles, scan_exp(6, 1, 13));
    period(p);
    chk(p, scan_exp(6, 1, 13));
    wr(8'h5d, 8'h27);
    idle();
    electrode_enable_field <= 4'h1;
    prox_enable_field <= 2'h0;
    period(p);
    chk(p, CPM << 7);
    $display("test override and interval done");
    electrode_enable_field <= 4'h0;
    auto_config_enable <= 1'b1;
    skip_time_search <= 1'b1;
    do_reset();
    electrode_enable_field <= 4'h1;
    trials(6, 0, 6'h01, v);
    wait_lvl(1'b1, 1'b0);
    @(posedge ref_clk);
    rd(8'h5f, {2'b00, v});
    chk(eff_current_flat[5:0], v != 0 ? v : 6'h10);
    electrode_enable_field <= 4'h0;
    repeat (4) idle();
    electrode_enable_field <= 4'h1;
    n = 0;
    repeat (60) @(negedge ref_clk) n += (trial_req === 1'b1);
    chk(n, 0);
    @(posedge ref_clk);
    $display("test search with skip done");
    electrode_enable_field <= 4'h0;
    skip_time_search <= 1'b0;
    do_reset();
    electrode_enable_field <= 4'h1;
    trials(3, 1, 6'h10, v);
    t = v[2:0];
    trials(6, 0, {3'b000, t}, v);
    wait_lvl(1'b1, 1'b0);
    chk(eff_time_flat[2:0], t != 0 ? t : 3'h1);
    $display("test search with time done");
    stop_test();
  end
endmodule
